// ===== design/dsf_defines.svh
/*
 * constants of the serial frame decoder: frame layout, select codes,
 * reset values. assumes inclusion by the package, the decoder and the bench.
 */
`ifndef DSF_DEFINES_SVH
`define DSF_DEFINES_SVH

// frame layout
`define DSF_FRAME_W     24
`define DSF_RW_BIT      23
`define DSF_ZERO_BIT    22
`define DSF_SEL_HI      21
`define DSF_SEL_LO      19
`define DSF_CH_HI       18
`define DSF_CH_LO       16
`define DSF_PAY_W       16
`define DSF_CODE_LO     4
`define DSF_LAST_BIT    5'h17

// register select codes
`define DSF_SEL_DAC     3'h0
`define DSF_SEL_RANGE   3'h1
`define DSF_SEL_POWER   3'h2
`define DSF_SEL_CTRL    3'h3

// channel codes; the control register reuses the field as a function code
`define DSF_CH_A        3'h0
`define DSF_CH_B        3'h2
`define DSF_CH_BOTH     3'h4
`define DSF_FN_NOP      3'h0
`define DSF_FN_SETUP    3'h1
`define DSF_FN_CLEAR    3'h4
`define DSF_FN_LOAD     3'h5

// range codes from this value upward are bipolar
`define DSF_RANGE_BIPOL 3'h3

// clear codes: zero output, or midscale / negative full scale
`define DSF_CLEAR_ZERO  12'h000
`define DSF_CLEAR_ALT   12'h800

// reset values
`define DSF_RST_CODE    12'h000
`define DSF_RST_RANGE   3'h0
`define DSF_RST_POWER   16'h0000
`define DSF_RST_CTRL    4'h0

`endif

// ===== design/dsf_pkg.sv
/*
 * types of the serial frame decoder.
 * assumes dsf_defines.svh is on the include path.
 */
`include "dsf_defines.svh"

package dsf_pkg;
	typedef logic [`DSF_FRAME_W-1:0] dsf_frame_t;
	typedef logic [`DSF_PAY_W-1:0]   dsf_payload_t;
	typedef enum logic [2:0] {
		DSF_REG_DAC   = `DSF_SEL_DAC,
		DSF_REG_RANGE = `DSF_SEL_RANGE,
		DSF_REG_POWER = `DSF_SEL_POWER,
		DSF_REG_CTRL  = `DSF_SEL_CTRL
	} dsf_reg_sel_t;
endpackage

// ===== design/dsf_frame_decoder.sv
/*
 * serial command frame decoder of a dual channel 12-bit converter:
 * shifts 24-bit frames in on the link clock, hands each whole frame to the
 * core clock and decodes it into the channel, range, power and control
 * registers, with readback of any of them.
 * assumes: the serial master keeps frame_sync_n_i low for exactly 24 link
 * clock falling edges per frame and idles the link clock between frames;
 * frames are spaced by at least 8 core clock cycles.
 */
`timescale 1ns/1ps
`include "dsf_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Contract
// - a command is exactly 24 bits, gathered into one frame register first.
// - frame bits arrive most significant bit first and are shifted in so.
// - bit 23 is read/write, 22 reserved, 21:19 register, 18:16 channel, 15:0 data.
// - the read/write flag chooses readback or write of the addressed register.
// - select 000 is DAC data, 001 output range, 010 power control, 011 control.
// - channel 000 is channel A, 010 channel B, 100 both channels.
// - every register reached by a frame can be written and read back.
// - in bipolar ranges the 12-bit code is signed twos complement.
// - in unipolar ranges the 12-bit code is unsigned straight binary.
// - the DAC code sits in data bits 15 to 4 and the low four are ignored.
module dsf_frame_decoder #(
	parameter int CH_N   = 2,
	parameter int CODE_W = 12
) (
	// core clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        reset_i,
	// serial link
	input  wire logic                        link_clk_i,
	input  wire logic                        frame_sync_n_i,
	input  wire logic                        serial_data_in_i,
	// decoded channel state and shared power and control registers
	output logic [CH_N-1:0][CODE_W-1:0]      dac_code_o,
	output logic [CH_N-1:0][CODE_W:0]        dac_level_o,
	output logic [CH_N-1:0][2:0]             range_o,
	output logic [`DSF_PAY_W-1:0]            power_o,
	output logic [3:0]                       ctrl_o,
	// command pulses
	output logic                             clear_o,
	output logic                             load_o,
	// readback
	output logic [`DSF_PAY_W-1:0]            readback_o,
	output logic                             readback_valid_o
);

	////////////////////////////////////////////////////////////////////////
	// link domain: shift in, msb first

	logic [4:0]                 bit_cnt;
	logic [`DSF_FRAME_W-2:0]    shift;
	dsf_pkg::dsf_frame_t        frame_link;
	logic                       frame_tgl;
	wire                        link_idle = reset_i | frame_sync_n_i;

	// the count restarts whenever sync is high, so a short frame is dropped
	always_ff @(negedge link_clk_i or posedge link_idle) begin
		if (link_idle) begin
			bit_cnt <= 5'h00;
		end else begin
			bit_cnt <= (bit_cnt == `DSF_LAST_BIT) ? 5'h00 : bit_cnt + 5'h01;
		end
	end

	// data bits are taken on the falling edge of the link clock
	always_ff @(negedge link_clk_i or posedge reset_i) begin
		if (reset_i) begin
			shift      <= '0;
			frame_link <= '0;
			frame_tgl  <= 1'b0;
		end else if (!frame_sync_n_i) begin
			shift <= {shift[`DSF_FRAME_W-3:0], serial_data_in_i};
			if (bit_cnt == `DSF_LAST_BIT) begin
				frame_link <= {shift, serial_data_in_i};
				frame_tgl  <= ~frame_tgl;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// crossing: the toggle passes three flops; the frame word stays put
	// for at least 24 link edges, far longer than the toggle takes

	logic tgl_s1;
	logic tgl_s2;
	logic tgl_s3;
	logic tgl_seen;

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tgl_s1   <= 1'b0;
			tgl_s2   <= 1'b0;
			tgl_s3   <= 1'b0;
			tgl_seen <= 1'b0;
		end else begin
			tgl_s1   <= frame_tgl;
			tgl_s2   <= tgl_s1;
			tgl_s3   <= tgl_s2;
			tgl_seen <= (tgl_s2 == tgl_s3) ? tgl_s3 : tgl_seen;
		end
	end

	// a new frame counts once the second and third stage agree
	wire frame_evt = (tgl_s2 == tgl_s3) && (tgl_s3 != tgl_seen);

	////////////////////////////////////////////////////////////////////////
	// field decode

	wire                       is_read = frame_link[`DSF_RW_BIT];
	wire [2:0]                 sel     = frame_link[`DSF_SEL_HI:`DSF_SEL_LO];
	wire [2:0]                 chan    = frame_link[`DSF_CH_HI:`DSF_CH_LO];
	wire dsf_pkg::dsf_payload_t payload = frame_link[`DSF_PAY_W-1:0];
	wire [CODE_W-1:0]          code_in = payload[`DSF_PAY_W-1:`DSF_CODE_LO];

	// the reserved bit is not checked; the master keeps it at zero
	wire sel_dac   = (sel == dsf_pkg::DSF_REG_DAC);
	wire sel_range = (sel == dsf_pkg::DSF_REG_RANGE);
	wire sel_power = (sel == dsf_pkg::DSF_REG_POWER);
	wire sel_ctrl  = (sel == dsf_pkg::DSF_REG_CTRL);

	wire hit_both  = (chan == `DSF_CH_BOTH);
	wire hit_a     = (chan == `DSF_CH_A) | hit_both;
	wire hit_b     = (chan == `DSF_CH_B) | hit_both;
	wire [CH_N-1:0] hit = {hit_b, hit_a};

	wire do_write  = frame_evt & ~is_read;
	wire do_read   = frame_evt & is_read;

	// power control has no channel; only the channel A pattern is legal
	wire wr_power  = do_write & sel_power & (chan == `DSF_CH_A);
	wire wr_ctrl   = do_write & sel_ctrl & (chan == `DSF_FN_SETUP);
	wire do_clear  = do_write & sel_ctrl & (chan == `DSF_FN_CLEAR);
	wire do_load   = do_write & sel_ctrl & (chan == `DSF_FN_LOAD);

	// clear code depends on the clear select control bit
	wire [CODE_W-1:0] clear_code = ctrl_o[1] ? `DSF_CLEAR_ALT : `DSF_CLEAR_ZERO;

	////////////////////////////////////////////////////////////////////////
	// per channel data, range and output level

	genvar ch;
	generate
		for (ch = 0; ch < CH_N; ch++) begin : g_ch
			wire wr_dac = do_write & sel_dac & hit[ch];
			wire wr_rng = do_write & sel_range & hit[ch];
			wire bipol  = (range_o[ch] >= `DSF_RANGE_BIPOL);
			wire [CODE_W:0] level = bipol ?
				{dac_code_o[ch][CODE_W-1], dac_code_o[ch]} :
				{1'b0, dac_code_o[ch]};

			// a write to the data register wins over a clear in the same cycle
			always_ff @(posedge core_clk_i or posedge reset_i) begin
				if (reset_i) begin
					dac_code_o[ch]  <= `DSF_RST_CODE;
					range_o[ch]     <= `DSF_RST_RANGE;
					dac_level_o[ch] <= '0;
				end else begin
					if (wr_dac) begin
						dac_code_o[ch] <= code_in;
					end else if (do_clear) begin
						dac_code_o[ch] <= clear_code;
					end
					if (wr_rng) begin
						range_o[ch] <= payload[2:0];
					end
					dac_level_o[ch] <= level;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// shared registers and command pulses

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			power_o <= `DSF_RST_POWER;
			ctrl_o  <= `DSF_RST_CTRL;
			clear_o <= 1'b0;
			load_o  <= 1'b0;
		end else begin
			power_o <= wr_power ? payload : power_o;
			ctrl_o  <= wr_ctrl ? payload[3:0] : ctrl_o;
			clear_o <= do_clear;
			load_o  <= do_load;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// readback: channel B only when addressed alone, otherwise channel A

	wire rd_ch = (chan == `DSF_CH_B);
	wire rd_chan_ok = hit_a | hit_b;
	wire [`DSF_PAY_W-1:0] rd_value =
		sel_dac   ? {dac_code_o[rd_ch], 4'h0} :
		sel_range ? {13'h0000, range_o[rd_ch]} :
		sel_power ? power_o :
		{12'h000, ctrl_o};
	// control readback ignores the channel field; others need a legal one
	wire rd_ok = do_read & (sel_ctrl | (sel_power & (chan == `DSF_CH_A)) |
		((sel_dac | sel_range) & rd_chan_ok));

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			readback_o       <= '0;
			readback_valid_o <= 1'b0;
		end else begin
			readback_o       <= rd_ok ? rd_value : readback_o;
			readback_valid_o <= rd_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_write_dac_a;
		frame_evt && !is_read && sel_dac && hit_a;
	endsequence

	sequence s_read_any;
		frame_evt && is_read;
	endsequence

	dac_write_a: assert property (s_write_dac_a |=> dac_code_o[0] == $past(code_in))
		else $error("channel A code not taken from data bits 15 to 4");
	dac_both_a: assert property (frame_evt && !is_read && sel_dac && hit_both
		|=> dac_code_o[0] == dac_code_o[1])
		else $error("both-channel write left the channels different");
	bad_chan_a: assert property (frame_evt && !is_read && !hit_a && !hit_b
		|=> $stable(dac_code_o) && $stable(range_o))
		else $error("undefined channel pattern changed a register");
	read_no_write_a: assert property (s_read_any
		|=> $stable(dac_code_o) && $stable(range_o) && $stable(power_o))
		else $error("read frame altered a register");
	rb_pulse_a: assert property (readback_valid_o |=> !readback_valid_o)
		else $error("readback valid held longer than one cycle");
	rb_range_a: assert property (s_read_any ##0 sel_range ##0 hit_a && !hit_b
		|=> readback_valid_o && readback_o == {13'h0000, range_o[0]})
		else $error("range readback mismatch");
	// the level lags the code by one cycle, so it is held against the code of the cycle before
	level_bipol_a: assert property (range_o[0] >= `DSF_RANGE_BIPOL && $stable(dac_code_o[0])
		|=> dac_level_o[0] == {$past(dac_code_o[0][CODE_W-1]), $past(dac_code_o[0])})
		else $error("bipolar level not sign extended");
	level_unipol_a: assert property (range_o[0] < `DSF_RANGE_BIPOL && $stable(dac_code_o[0])
		|=> dac_level_o[0] == {1'b0, $past(dac_code_o[0])})
		else $error("unipolar level not zero extended");
	evt_once_a: assert property (frame_evt |=> !frame_evt [*2])
		else $error("one frame decoded twice");
	power_bad_a: assert property (frame_evt && !is_read && sel_power && chan != `DSF_CH_A
		|=> $stable(power_o))
		else $error("power register written with a bad channel field");

endmodule

// ===== dv/dsf_master_model.sv
/*
 * serial master model: sends frames msb first on a link clock that stands
 * still (high) between frames. assumes the decoder samples on falling edges.
 */
`timescale 1ns/1ps
module dsf_master_model (
	// serial link towards the decoder
	output logic link_clk_o,
	output logic frame_sync_n_o,
	output logic serial_data_o
);
	// idle: clock parked high, sync released
	initial begin
		link_clk_o     = 1'b1;
		frame_sync_n_o = 1'b1;
		serial_data_o  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// data moves after the rising edge so it is settled at the falling one
	task automatic send_frame(input logic [23:0] frame, input int bits);
		frame[22] = 1'b0;
		#7.3;
		frame_sync_n_o = 1'b0;
		for (int i = 23; i > 23 - bits; i--) begin
			serial_data_o = frame[i];
			#40 link_clk_o = 1'b0;
			#40 link_clk_o = 1'b1;
		end
		// released line flips so a stale bit is never read as fresh
		frame_sync_n_o = 1'b1;
		serial_data_o  = ~serial_data_o;
	endtask
endmodule

// ===== dv/test_dsf_frame_decoder.sv
/*
 * bench of the frame decoder: corner and random frames, expected state
 * kept here. assumes the master model and the design header.
 */
`timescale 1ns/1ps
`include "dsf_defines.svh"
module test_dsf_frame_decoder;
	logic              core_clk_i;
	logic              reset_i;
	wire               link_clk_i;
	wire               frame_sync_n_i;
	wire               serial_data_in_i;
	logic [1:0][11:0]  dac_code_o;
	logic [1:0][12:0]  dac_level_o;
	logic [1:0][2:0]   range_o;
	logic [15:0]       power_o, readback_o, e_power, e_rb, rb_word, d;
	logic [3:0]        ctrl_o, e_ctrl;
	logic              clear_o, load_o, readback_valid_o, rw;
	logic [11:0]       e_code [2];
	logic [2:0]        e_range [2];
	logic [2:0]        s, c;
	logic [15:0]       n_clear, n_load, n_rb, e_clear, e_load, e_nrb;
	int                bad_count, num_checks, cycles;

	dsf_frame_decoder dsf_frame_decoder_inst (.core_clk_i, .reset_i, .link_clk_i,
		.frame_sync_n_i, .serial_data_in_i, .dac_code_o, .dac_level_o, .range_o,
		.power_o, .ctrl_o, .clear_o, .load_o, .readback_o, .readback_valid_o);
	dsf_master_model dsf_master_model_inst (.link_clk_o(link_clk_i),
		.frame_sync_n_o(frame_sync_n_i), .serial_data_o(serial_data_in_i));

	// core clock, 100 MHz
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	// pulse counters and hang guard; pulses are looked at mid-cycle, where they are settled
	always @(negedge core_clk_i) begin
		cycles++;
		if (clear_o === 1'b1) n_clear++;
		if (load_o === 1'b1) n_load++;
		if (readback_valid_o === 1'b1) begin
			n_rb++;
			rb_word = readback_o;
		end
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// level as the converter sees the code in the current range
	function automatic logic [12:0] lvl(input logic [11:0] k, input logic [2:0] r);
		return (r >= `DSF_RANGE_BIPOL) ? {k[11], k} : {1'b0, k};
	endfunction

	// expected effect of one frame; refused patterns fall through untouched
	task automatic expect_frame();
		logic ab, ok;
		int   x;
		ab = (c == `DSF_CH_A) || (c == `DSF_CH_B) || (c == `DSF_CH_BOTH);
		ok = (s <= 3'h1) ? ab : (s == 3'h2) ? (c == 3'h0) : (s == 3'h3);
		x  = (c == `DSF_CH_B) ? 1 : 0;
		if (rw && ok) begin
			e_nrb++;
			e_rb = (s == 3'h0) ? {e_code[x], 4'h0} : (s == 3'h1) ? {13'h0, e_range[x]} :
				(s == 3'h2) ? e_power : {12'h0, e_ctrl};
		end else if (!rw && ok) begin
			if (s == 3'h0 && c != `DSF_CH_B) e_code[0] = d[15:4];
			if (s == 3'h0 && c != `DSF_CH_A) e_code[1] = d[15:4];
			if (s == 3'h1 && c != `DSF_CH_B) e_range[0] = d[2:0];
			if (s == 3'h1 && c != `DSF_CH_A) e_range[1] = d[2:0];
			if (s == 3'h2) e_power = d;
			if (s == 3'h3 && c == `DSF_FN_SETUP) e_ctrl = d[3:0];
			if (s == 3'h3 && c == `DSF_FN_LOAD) e_load++;
			if (s == 3'h3 && c == `DSF_FN_CLEAR) begin
				e_clear++;
				e_code = '{2{e_ctrl[1] ? `DSF_CLEAR_ALT : `DSF_CLEAR_ZERO}};
			end
		end
	endtask

	task automatic compare_all();
		for (int i = 0; i < 2; i++) begin
			check("code", dac_code_o[i], e_code[i]);
			check("range", range_o[i], e_range[i]);
			check("level", dac_level_o[i], lvl(e_code[i], e_range[i]));
		end
		check("power", power_o, e_power);
		check("ctrl", ctrl_o, e_ctrl);
		check("clears", n_clear, e_clear);
		check("loads", n_load, e_load);
		check("reads", n_rb, e_nrb);
		check("read word", rb_word, e_rb);
	endtask

	task automatic run_frame(input logic r, input logic [2:0] sl, ch, input logic [15:0] dt);
		{rw, s, c, d} = {r, sl, ch, dt};
		dsf_master_model_inst.send_frame({rw, 1'b0, s, c, d}, 24);
		expect_frame();
		repeat (10) @(negedge core_clk_i);
		compare_all();
	endtask

	task automatic do_reset();
		reset_i = 1'b1;
		repeat (10) @(negedge core_clk_i);
		reset_i = 1'b0;
		{e_power, e_ctrl, e_rb, rb_word} = '0;
		{n_clear, n_load, n_rb, e_clear, e_load, e_nrb} = '0;
		e_code = '{2{12'h000}};
		e_range = '{2{3'h0}};
		@(negedge core_clk_i);
		compare_all();
	endtask

	////////////////////////////////////////////////////////////////////////
	// corners first, then random frames, then a second reset
	initial begin
		{reset_i, bad_count, num_checks, cycles} = '0;
		void'($urandom(71836));
		do_reset();
		dsf_master_model_inst.send_frame(24'h00ffff, 10);
		run_frame(0, 3'h0, 3'h0, 16'h1230);
		run_frame(0, 3'h1, 3'h4, 16'h0003);
		run_frame(0, 3'h0, 3'h4, 16'h8000);
		run_frame(0, 3'h0, 3'h2, 16'h7ff5);
		run_frame(0, 3'h3, 3'h1, 16'h0002);
		run_frame(0, 3'h3, 3'h4, 16'h0000);
		run_frame(1, 3'h3, 3'h1, 16'h0000);
		run_frame(1, 3'h0, 3'h1, 16'h0000);
		run_frame(0, 3'h1, 3'h0, 16'h0000);
		run_frame(0, 3'h0, 3'h0, 16'hfff0);
		run_frame(0, 3'h2, 3'h0, 16'ha5c3);
		run_frame(0, 3'h2, 3'h4, 16'hffff);
		run_frame(0, 3'h5, 3'h0, 16'hffff);
		run_frame(0, 3'h0, 3'h6, 16'hffff);
		run_frame(0, 3'h3, 3'h5, 16'h0000);
		run_frame(0, 3'h3, 3'h0, 16'h000f);
		run_frame(0, 3'h3, 3'h1, 16'h0000);
		run_frame(0, 3'h3, 3'h4, 16'h0000);
		for (int k = 0; k < 40; k++) begin
			rw = 1'($urandom_range(1, 0));
			s = 3'($urandom_range(7, 0));
			c = 3'($urandom_range(7, 0));
			if (rw) s = {1'b0, s[1:0]};
			if (rw && s == 3'h3) c = 3'h1;
			run_frame(rw, s, c, 16'($urandom));
		end
		do_reset();
		run_frame(1, 3'h2, 3'h0, 16'h0000);
		complete_run();
	end
endmodule
